// ==== rtl/svp_top.sv ====
// Shared video RAM controller with colour pipeline and palette.
// Assumes CPU request and config ports come from logic on clk;
// DRAM data pins are asynchronous and are synchronised here.
//
// Operation
// - Control 128K DRAM shared, 16K/32K screen
// - Fetch only after timing marked loaded
// - Address mux: display/CPU, row/column
// - Generate strobes; stall CPU with wait
// - CPU data only through internal latches
// - 64K x 16 array, full word captured
// - Fetched word into attribute, character latches
// - Character pattern in alpha, shifter in graphics
// - Foreground/background pick from pattern bit
// - Merge compat colour, pre-palette latch
// - Palette index mux; write uses address
// - Mask forces chosen colour bits zero
// - Remap sixteen codes, identity, immediate
// - Post-palette register before border mux
// - Border mux substitutes border colour
// - Border latch only in extended modes
`timescale 1ns/100ps
`include "svp_params.svh"
module svp_top (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clkEn,
    // CPU side
    input  wire logic                 cpuReq,
    input  wire logic                 cpuWrite,
    input  wire logic [15:0]          cpuAddr,
    input  wire svp_pkg::svp_word_t   cpuWrData,
    output svp_pkg::svp_word_t        cpuRdData,
    output logic                      cpuAck,
    output logic                      cpuStallRequest_n,
    // Configuration
    input  wire logic                 timingLoaded,
    input  wire logic                 screen32k,
    input  wire logic                 graphicsMode,
    input  wire logic                 extendedMode,
    input  wire logic [15:0]          screenBase,
    input  wire svp_pkg::svp_colour_t compatColour,
    input  wire svp_pkg::svp_colour_t paletteMask,
    input  wire logic                 palWrite,
    input  wire svp_pkg::svp_colour_t palAddr,
    input  wire svp_pkg::svp_colour_t palData,
    input  wire svp_pkg::svp_colour_t borderColour,
    // DRAM pins
    output logic [7:0]                dramAddr,
    output logic                      dramRas_n,
    output logic                      dramCas_n,
    output logic                      dramWe_n,
    output svp_pkg::svp_word_t        dramDataOut,
    output logic                      dramDataOe,
    input  wire svp_pkg::svp_word_t   dramDataIn,
    // Pixel output
    output svp_pkg::svp_colour_t      fourBitColourCode,
    output logic                      pixelValid
);
    // Reset release chain
    logic [1:0]           rstPipe_reg;    // Release synchroniser
    logic                 rstSync_n;      // Released reset
    // DRAM data synchroniser
    svp_pkg::svp_word_t   dataSync1_reg;  // First stage
    svp_pkg::svp_word_t   dataSync2_reg;  // Second stage
    // Sequencer
    svp_pkg::svp_dram_e   state_reg;      // Access state
    svp_pkg::svp_dram_e   state_next;     // Next access state
    logic                 isDisp_reg;     // Current access is a fetch
    logic                 isDisp_next;    // Owner of next access
    logic [1:0]           wait_reg;       // Read settle counter
    logic [15:0]          fetchOff_reg;   // Offset in screen window
    logic [15:0]          scrWords;       // Screen size in words
    logic [15:0]          fetchAddr;      // Display word address
    logic                 dispReq;        // Display wants a word
    logic                 cpuPend;        // CPU wants an access
    logic                 cpuDone;        // CPU access finishing
    // Raster and pixel pipe
    logic [9:0]           hCnt_reg;       // Pixel column
    logic [9:0]           vCnt_reg;       // Scan line
    logic [2:0]           idx0_reg;       // Pixel within word
    logic [2:0]           idx1_reg;       // Index at latch stage
    logic [2:0]           lastIdx;        // Pixels per word minus one
    logic                 active;         // Inside picture area
    logic                 needWord;       // First pixel of a word
    logic                 advance;        // Pipe moves this cycle
    logic [7:0]           attr_reg;       // Attribute latch
    logic [7:0]           char_reg;       // Character latch
    svp_pkg::svp_word_t   shift_reg;      // Graphics shifter
    logic [7:0]           pattern;        // Character row pattern
    svp_pkg::svp_colour_t code;           // Mux output colour
    svp_pkg::svp_colour_t prePal_reg;     // Pre-palette latch
    svp_pkg::svp_colour_t palIdx;         // Palette index
    svp_pkg::svp_colour_t palOut;         // Palette result
    svp_pkg::svp_colour_t postPal_reg;    // Post-palette register
    logic [2:0]           border_reg;     // Border flag delay line
    logic                 borderLatchOn;  // Border colour in use

    svp_stream_if #(.WIDTH(`SVP_DW)) fetchIf ();
    svp_stream_if #(.WIDTH(`SVP_DW)) pixIf ();

    // Selects one half of the display or CPU address
    function automatic logic [7:0] addrMux(
        input logic        disp,
        input logic        colHalf,
        input logic [15:0] dispA,
        input logic [15:0] cpuA
    );
        logic [15:0] a;
        a = disp ? dispA : cpuA;
        addrMux = colHalf ? a[`SVP_ROWCOL_W-1:0] : a[15:`SVP_ROWCOL_W];
    endfunction

    // Stand-in glyph generator for the character pattern store
    function automatic logic [7:0] charRow(
        input logic [7:0] ch,
        input logic [2:0] line
    );
        charRow = ch ^ {line, line, line[1:0]};
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_reg <= '0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_reg[1];

    // Two-stage synchroniser on the RAM data pins
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dataSync1_reg <= '0;
            dataSync2_reg <= '0;
        end else if (clkEn) begin
            dataSync1_reg <= dramDataIn;
            dataSync2_reg <= dataSync1_reg;
        end
    end

    // Screen window size and fetch address
    // screen window
    assign scrWords  = screen32k ? `SVP_SCR32_WORDS : `SVP_SCR16_WORDS;
    assign fetchAddr = 16'(screenBase + fetchOff_reg);

    // Request terms
    // display request gated by timing
    assign dispReq = timingLoaded && fetchIf.ready;
    assign cpuPend = cpuReq && !cpuAck;
    assign cpuDone = (state_reg == svp_pkg::SVP_DR_DONE) && !isDisp_reg;

    // Next state of the access sequencer
    always_comb begin
        state_next  = state_reg;
        isDisp_next = isDisp_reg;
        case (state_reg)
            svp_pkg::SVP_DR_IDLE: begin
                if (dispReq) begin
                    state_next  = svp_pkg::SVP_DR_ROW;
                    isDisp_next = 1'b1;
                end else if (cpuPend) begin
                    state_next  = svp_pkg::SVP_DR_ROW;
                    isDisp_next = 1'b0;
                end
            end
            svp_pkg::SVP_DR_ROW: begin
                state_next = svp_pkg::SVP_DR_COL;
            end
            svp_pkg::SVP_DR_COL: begin
                state_next = svp_pkg::SVP_DR_WAIT;
            end
            svp_pkg::SVP_DR_WAIT: begin
                // Let the word pass the synchroniser
                if (wait_reg == `SVP_READ_WAIT) begin
                    state_next = svp_pkg::SVP_DR_DONE;
                end
            end
            svp_pkg::SVP_DR_DONE: begin
                state_next = svp_pkg::SVP_DR_IDLE;
            end
            default: begin
                state_next = svp_pkg::SVP_DR_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg  <= svp_pkg::SVP_DR_IDLE;
            isDisp_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg  <= state_next;
            isDisp_reg <= isDisp_next;
        end
    end

    // Settle counter in the wait state
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wait_reg <= '0;
        end else if (clkEn) begin
            if (state_reg == svp_pkg::SVP_DR_WAIT) begin
                wait_reg <= wait_reg + 2'd1;
            end else begin
                wait_reg <= '0;
            end
        end
    end

    // RAM strobes and address, registered from the next state
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dramRas_n   <= 1'b1;
            dramCas_n   <= 1'b1;
            dramWe_n    <= 1'b1;
            dramAddr    <= '0;
            dramDataOut <= '0;
            dramDataOe  <= 1'b0;
        end else if (clkEn) begin
            dramRas_n <= !(state_next == svp_pkg::SVP_DR_ROW ||
                           state_next == svp_pkg::SVP_DR_COL ||
                           state_next == svp_pkg::SVP_DR_WAIT);
            dramCas_n <= !(state_next == svp_pkg::SVP_DR_COL ||
                           state_next == svp_pkg::SVP_DR_WAIT);
            dramWe_n  <= !(state_next == svp_pkg::SVP_DR_COL &&
                           !isDisp_next && cpuWrite);
            dramAddr  <= addrMux(isDisp_next,
                                 state_next != svp_pkg::SVP_DR_ROW,
                                 fetchAddr, cpuAddr);
            dramDataOut <= cpuWrData;
            dramDataOe  <= (state_next == svp_pkg::SVP_DR_COL ||
                            state_next == svp_pkg::SVP_DR_WAIT) &&
                           !isDisp_next && cpuWrite;
        end
    end

    // Display word offset, wraps at screen size
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fetchOff_reg <= '0;
        end else if (clkEn && fetchIf.valid && fetchIf.ready) begin
            if (fetchOff_reg == scrWords - 16'd1) begin
                fetchOff_reg <= '0;
            end else begin
                fetchOff_reg <= fetchOff_reg + 16'd1;
            end
        end
    end

    // Fetched word offered to the FIFO
    // whole word taken
    assign fetchIf.valid = (state_reg == svp_pkg::SVP_DR_DONE) && isDisp_reg;
    assign fetchIf.data  = dataSync2_reg;

    // CPU read latch and completion
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cpuRdData <= '0;
            cpuAck    <= 1'b0;
        end else if (clkEn) begin
            cpuAck <= cpuDone;
            if (cpuDone && !cpuWrite) begin
                cpuRdData <= dataSync2_reg;
            end
        end
    end

    // Wait request to the CPU
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cpuStallRequest_n <= 1'b1;
        end else if (clkEn) begin
            cpuStallRequest_n <= !(cpuReq && !cpuDone && !cpuAck);
        end
    end

    svp_fifo #(
        .WIDTH(`SVP_DW),
        .DEPTH(`SVP_FIFO_DEPTH)
    ) uFifo (
        .clk      (clk),
        .rstSync_n(rstSync_n),
        .clkEn    (clkEn),
        .inSide   (fetchIf),
        .outSide  (pixIf)
    );

    // Raster terms
    assign active   = (hCnt_reg < `SVP_H_ACTIVE) && (vCnt_reg < `SVP_V_ACTIVE);
    assign lastIdx  = graphicsMode ? `SVP_GFX_LAST : `SVP_ALPHA_LAST;
    assign needWord = active && (idx0_reg == 3'd0);
    // Pipe stalls when a word is due and none is buffered
    assign advance  = clkEn && timingLoaded && !(needWord && !pixIf.valid);
    assign pixIf.ready = needWord && timingLoaded;

    // Raster counters
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hCnt_reg <= '0;
            vCnt_reg <= '0;
        end else if (advance) begin
            if (hCnt_reg == `SVP_H_LAST) begin
                hCnt_reg <= '0;
                vCnt_reg <= (vCnt_reg == `SVP_V_LAST) ? 10'd0 : vCnt_reg + 10'd1;
            end else begin
                hCnt_reg <= hCnt_reg + 10'd1;
            end
        end
    end

    // Pixel index inside the current word
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            idx0_reg <= '0;
            idx1_reg <= '0;
        end else if (advance) begin
            idx1_reg <= idx0_reg;
            if (!active || idx0_reg == lastIdx) begin
                idx0_reg <= '0;
            end else begin
                idx0_reg <= idx0_reg + 3'd1;
            end
        end
    end

    // Attribute and character latches
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            attr_reg <= '0;
            char_reg <= '0;
        end else if (advance && needWord) begin
            attr_reg <= pixIf.data[15:8];
            char_reg <= pixIf.data[7:0];
        end
    end

    // Graphics shifter, loaded from the latches
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            shift_reg <= '0;
        end else if (advance) begin
            if (idx1_reg == 3'd0) begin
                shift_reg <= {attr_reg, char_reg} << `SVP_NIBBLE;
            end else begin
                shift_reg <= shift_reg << `SVP_NIBBLE;
            end
        end
    end

    // Colour code of the current pixel
    always_comb begin
        pattern = charRow(char_reg, vCnt_reg[2:0]);
        if (graphicsMode) begin
            code = (idx1_reg == 3'd0) ? attr_reg[7:4] : shift_reg[15:12];
        end else begin
            code = pattern[3'd7 - idx1_reg] ? attr_reg[3:0] : attr_reg[7:4];
        end
    end

    // Pre-palette latch
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            prePal_reg <= '0;
        end else if (advance) begin
            prePal_reg <= (code == 4'h0) ? compatColour : code;
        end
    end

    // Palette index: write address or masked colour
    // index mux
    assign palIdx = palWrite ? palAddr : (prePal_reg & ~paletteMask);

    svp_palette uPalette (
        .clk      (clk),
        .rstSync_n(rstSync_n),
        .clkEn    (clkEn),
        .wrEn     (palWrite),
        .idx      (palIdx),
        .wrData   (palData),
        .rdData   (palOut)
    );

    // Post-palette register and border flag delay
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            postPal_reg <= '0;
            border_reg  <= '0;
        end else if (advance) begin
            postPal_reg <= palOut;
            border_reg  <= {border_reg[1:0], !active};
        end
    end

    assign borderLatchOn = extendedMode;

    // Border mux onto the output register
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fourBitColourCode <= '0;
            pixelValid        <= 1'b0;
        end else if (clkEn) begin
            pixelValid <= advance;
            if (advance) begin
                if (border_reg[2]) begin
                    fourBitColourCode <= borderLatchOn ? borderColour : 4'h0;
                end else begin
                    fourBitColourCode <= postPal_reg;
                end
            end
        end
    end
endmodule // svp_top

// ==== rtl/svp_params.svh ====
// Constants for the shared video RAM and palette pipeline.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SVP_PARAMS_SVH
`define SVP_PARAMS_SVH
`define SVP_DW          16
`define SVP_CODE_W      4
`define SVP_ROWCOL_W    8
`define SVP_FIFO_DEPTH  4
`define SVP_PAL_ENTRIES 16
`define SVP_H_ACTIVE    10'd320
`define SVP_H_LAST      10'd399
`define SVP_V_ACTIVE    10'd200
`define SVP_V_LAST      10'd261
`define SVP_SCR16_WORDS 16'h2000
`define SVP_SCR32_WORDS 16'h4000
`define SVP_GFX_LAST    3'd3
`define SVP_ALPHA_LAST  3'd7
`define SVP_READ_WAIT   2'd2
`define SVP_NIBBLE      4
`endif

// ==== rtl/svp_pkg.sv ====
// Types shared by the video pipeline modules.
// Assumes svp_params.svh is on the include path.
package svp_pkg;
    // DRAM access sequencer states
    typedef enum logic [2:0] {
        SVP_DR_IDLE = 3'b000,
        SVP_DR_ROW  = 3'b001,
        SVP_DR_COL  = 3'b010,
        SVP_DR_WAIT = 3'b011,
        SVP_DR_DONE = 3'b100
    } svp_dram_e;
    typedef logic [15:0] svp_word_t;
    typedef logic [3:0]  svp_colour_t;
endpackage

// ==== rtl/svp_stream_if.sv ====
// Valid/ready word stream between the pipeline's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface svp_stream_if #(parameter int WIDTH = 16);
    logic             valid;  // Word offered
    logic             ready;  // Word accepted
    logic [WIDTH-1:0] data;   // Word itself
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/svp_fifo.sv ====
// Word FIFO held in flip-flops, width and depth as parameters.
// Assumes synchronous reset copy and a shared clock enable.
`timescale 1ns/100ps
module svp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic rstSync_n,
    input  wire logic clkEn,
    svp_stream_if.snk inSide,
    svp_stream_if.src outSide
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
    logic [AW:0]      wrPtr_reg;        // Write pointer, wrap bit on top
    logic [AW:0]      rdPtr_reg;        // Read pointer, wrap bit on top
    logic             full;             // All entries hold data
    logic             empty;            // No entry holds data
    logic             doWr;             // Push this cycle
    logic             doRd;             // Pop this cycle

    // Full when pointers differ only in the wrap bit
    assign full  = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    assign empty = (wrPtr_reg == rdPtr_reg);
    assign inSide.ready  = !full;
    assign outSide.valid = !empty;
    assign outSide.data  = mem_reg[rdPtr_reg[AW-1:0]];
    assign doWr = clkEn && inSide.valid && !full;
    assign doRd = clkEn && outSide.ready && !empty;

    // Pointer update
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doWr) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRd) rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end

    // Entry write, no reset needed for data
    always_ff @(posedge clk) begin
        if (doWr) mem_reg[wrPtr_reg[AW-1:0]] <= inSide.data;
    end
endmodule // svp_fifo

// ==== rtl/svp_palette.sv ====
// Sixteen-entry colour remap table in flip-flops.
// Assumes the caller muxes the index between lookup and write.
`timescale 1ns/100ps
`include "svp_params.svh"
module svp_palette (
    input  wire logic                 clk,
    input  wire logic                 rstSync_n,
    input  wire logic                 clkEn,
    input  wire logic                 wrEn,
    input  wire svp_pkg::svp_colour_t idx,
    input  wire svp_pkg::svp_colour_t wrData,
    output svp_pkg::svp_colour_t      rdData
);
    svp_pkg::svp_colour_t entry_reg [`SVP_PAL_ENTRIES];  // Table

    // Read is immediate, so a write shows on the next pixel
    assign rdData = entry_reg[idx];

    // One flop group per entry, identity after reset
    for (genvar g = 0; g < `SVP_PAL_ENTRIES; g++) begin : gEntry
        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                entry_reg[g] <= svp_pkg::svp_colour_t'(g);
            end else if (clkEn && wrEn && idx == svp_pkg::svp_colour_t'(g)) begin
                entry_reg[g] <= wrData;
            end
        end
    end
endmodule // svp_palette

// ==== bench/svp_dram_model.sv ====
// Behavioural 64K x 16 DRAM on the controller's pins.
// Assumes row on RAS fall, column on CAS fall.
`timescale 1ns/100ps
module svp_dram_model (
    input  wire logic               dramRas_n,
    input  wire logic               dramCas_n,
    input  wire logic               dramWe_n,
    input  wire logic [7:0]         dramAddr,
    input  wire svp_pkg::svp_word_t dramDataOut,
    output svp_pkg::svp_word_t      dramDataIn
);
    svp_pkg::svp_word_t mem [0:65535];
    logic [7:0]         row_reg;  // Row half
    logic [15:0]        cell_reg; // Full address
    svp_pkg::svp_word_t last_reg; // Last word shown
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        cell_reg = 16'h0000;
        last_reg = 16'h0000;
    end
    // Row half taken at RAS fall, after pins settle
    always @(negedge dramRas_n) begin
        #1;
        row_reg = dramAddr;
    end
    // Column taken, write done after pins settle
    always @(negedge dramCas_n) begin
        #1;
        cell_reg = {row_reg, dramAddr};
        if (!dramWe_n) begin
            mem[cell_reg] = dramDataOut;
        end
    end
    // Remember what was shown for the idle pattern
    always @(posedge dramCas_n) last_reg = mem[cell_reg];
    // Data only while CAS low, else inverse of last
    assign dramDataIn = !dramCas_n ? mem[cell_reg] : ~last_reg;
endmodule // svp_dram_model

// ==== bench/svp_top_chk.sv ====
// Port checks on the shared video RAM controller.
// Assumes one clock and clkEn held high by the bench.
`timescale 1ns/100ps
module svp_top_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpuReq,
    input wire logic cpuAck,
    input wire logic cpuStallRequest_n,
    input wire logic timingLoaded,
    input wire logic dramRas_n,
    input wire logic dramCas_n,
    input wire logic dramWe_n,
    input wire logic dramDataOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // New request while no answer stands
    sequence sReqRise;
        $rose(cpuReq) && !cpuAck;
    endsequence
    // Column strobe falls
    sequence sColStart;
        $fell(dramCas_n);
    endsequence
    AST_STALL_SET: assert property (sReqRise |=> !cpuStallRequest_n)
        else $error("stall not raised");
    AST_ACK_BOUND: assert property (sReqRise |-> ##[5:1000] cpuAck)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (cpuAck |=> !cpuAck)
        else $error("ack too long");
    AST_ACK_RELEASE: assert property (cpuAck |-> cpuStallRequest_n && $past(cpuReq, 5))
        else $error("ack timing wrong");
    AST_STALL_CAUSE: assert property (!cpuStallRequest_n |-> cpuReq)
        else $error("stall without request");
    AST_CAS_IN_RAS: assert property (sColStart |-> !dramRas_n)
        else $error("column outside row");
    AST_WRITE_DRIVE: assert property (sColStart ##0 !dramWe_n |-> dramDataOe)
        else $error("write not driven");
    AST_OE_WITH_WE: assert property (dramDataOe |-> !dramRas_n && !dramCas_n
        && (!dramWe_n || $past(dramDataOe)))
        else $error("drive outside write");
    AST_IDLE_NO_FETCH: assert property (!timingLoaded && !$past(timingLoaded, 8)
        && !cpuReq && !$past(cpuReq) |-> dramRas_n)
        else $error("fetch before timing");
endmodule // svp_top_chk
bind svp_top svp_top_chk svp_top_chk_inst (.clk(clk), .rst_n(rst_n), .cpuReq(cpuReq),
    .cpuAck(cpuAck), .cpuStallRequest_n(cpuStallRequest_n), .timingLoaded(timingLoaded),
    .dramRas_n(dramRas_n), .dramCas_n(dramCas_n), .dramWe_n(dramWe_n),
    .dramDataOe(dramDataOe));

// ==== bench/svp_top_tb_top.sv ====
// Bench for the shared video RAM controller.
// Assumes the DRAM model on the pins and clkEn held high.
`timescale 1ns/100ps
module svp_top_tb_top;
    logic clk = 0, rst_n = 0, cpuReq = 0, cpuWrite = 0, timingLoaded = 0;
    logic screen32k = 0, graphicsMode = 1, extendedMode = 0, palWrite = 0;
    logic [15:0] cpuAddr = 16'h0000, screenBase = 16'h0000;
    svp_pkg::svp_word_t cpuWrData = 16'h0000, cpuRdData, dramDataOut, dramDataIn;
    svp_pkg::svp_colour_t compatColour = 4'h3, paletteMask = 4'hf, palAddr = 4'h0;
    svp_pkg::svp_colour_t palData = 4'h0, borderColour = 4'h5, fourBitColourCode;
    logic cpuAck, cpuStallRequest_n, dramRas_n, dramCas_n, dramWe_n, dramDataOe, pixelValid;
    logic [7:0] dramAddr;
    int nErrors = 0, comparisons = 0;
    logic [15:0] addrTab [3] = '{16'h0000, 16'hffff, 16'h1234}; // Edge and middle addresses
    // Clock, 50 ns period
    always #25 clk = ~clk;
    svp_top svp_top_inst (.clk, .rst_n, .clkEn(1'b1), .cpuReq, .cpuWrite, .cpuAddr,
        .cpuWrData, .cpuRdData, .cpuAck, .cpuStallRequest_n, .timingLoaded, .screen32k,
        .graphicsMode, .extendedMode, .screenBase, .compatColour, .paletteMask, .palWrite,
        .palAddr, .palData, .borderColour, .dramAddr, .dramRas_n, .dramCas_n, .dramWe_n,
        .dramDataOut, .dramDataOe, .dramDataIn, .fourBitColourCode, .pixelValid);
    svp_dram_model svp_dram_model_inst (.dramRas_n, .dramCas_n, .dramWe_n, .dramAddr,
        .dramDataOut, .dramDataIn);
    // Verdict and end of run
    task automatic results;
        $display("errors %0d comparisons %0d", nErrors, comparisons);
        if (nErrors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Word compare
    task automatic chk_word(input svp_pkg::svp_word_t got, input svp_pkg::svp_word_t exp);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %0t word %h expected %h", $time, got, exp);
        end
    endtask
    // Colour compare
    task automatic chk_col(input svp_pkg::svp_colour_t got, input svp_pkg::svp_colour_t exp);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %0t colour %h expected %h", $time, got, exp);
        end
    endtask
    // One CPU access, held until acknowledged
    task automatic cpu_access(input logic wr, input logic [15:0] a, input svp_pkg::svp_word_t d);
        int i;
        @(negedge clk);
        {cpuReq, cpuWrite, cpuAddr, cpuWrData} = {1'b1, wr, a, d};
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (cpuAck !== 1'b1 && i < 2000);
        if (i >= 2000) begin
            nErrors++;
            $display("mismatch %0t no acknowledge", $time);
            results;
        end
        @(negedge clk);
        cpuReq = 0;
    endtask
    // Pixels must be colour a or b, b seen at least once
    task automatic scan(input svp_pkg::svp_colour_t a, input svp_pkg::svp_colour_t b);
        int nb;
        nb = 0;
        repeat (20) @(posedge clk);
        repeat (4000) begin
            @(posedge clk);
            #1;
            if (pixelValid === 1'b1) begin
                if (fourBitColourCode === b) nb++;
                else chk_col(fourBitColourCode, a);
            end
        end
        chk_col((nb > 0) ? b : ~b, b);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 6; k++) begin
            if (k == 3) timingLoaded = 1;
            cpu_access(1'b1, addrTab[k % 3], 16'ha5c3 ^ 16'(k * 16'h1111));
            chk_word(svp_dram_model_inst.mem[addrTab[k % 3]], 16'ha5c3 ^ 16'(k * 16'h1111));
            cpu_access(1'b0, addrTab[k % 3], 16'h0000);
            chk_word(cpuRdData, 16'ha5c3 ^ 16'(k * 16'h1111));
        end
        scan(4'h0, 4'h0);
        @(negedge clk);
        palWrite = 1;
        palData = 4'h9;
        @(negedge clk);
        palWrite = 0;
        scan(4'h0, 4'h9);
        @(negedge clk);
        extendedMode = 1;
        scan(4'h9, 4'h5);
        cpu_access(1'b1, 16'h0000, 16'h0000);
        cpu_access(1'b1, 16'h1234, 16'h0000);
        @(negedge clk);
        {screen32k, graphicsMode, paletteMask} = {1'b1, 1'b0, 4'h0};
        scan(4'h3, 4'h5);
        results;
    end
endmodule // svp_top_tb_top
